// ### rtl/scan_regs_pkg.sv
// Purpose: Constants for the boundary-scan test data registers.
// Assumes: One core clock; scan pins are sampled into it.
// Notes: Chain index 0 sits next to the test data output.
package scan_regs_pkg;
  // -------------------------------------------------------------
  // Instruction codes.
  // -------------------------------------------------------------
  localparam logic [3:0] INS_EXTEST = 4'h0;
  localparam logic [3:0] INS_SAMPLE = 4'h3;
  localparam logic [3:0] INS_CLAMP = 4'h5;
  localparam logic [3:0] INS_HIGHZ = 4'h7;
  localparam logic [3:0] INS_CLAMPZ = 4'h9;
  localparam logic [3:0] INS_INTEST = 4'hC;
  localparam logic [3:0] INS_IDCODE = 4'hE;
  localparam logic [3:0] INS_BYPASS = 4'hF;
  // -------------------------------------------------------------
  // Register sizes, field positions and chain layout.
  // -------------------------------------------------------------
  localparam int ID_W = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MAKER_LSB = 1;
  localparam int DATA_BITS = 10;
  localparam int CHAIN_LEN = 23;
  localparam int DOE_IDX = 2;
  localparam int AOUT_IDX = 1;
  localparam int AOE_IDX = 0;
  localparam logic BYPASS_CAPTURE = 1'b0;
  // -------------------------------------------------------------
  // Output buffer shape.
  // -------------------------------------------------------------
  localparam int BUF_W = 1;
  localparam int BUF_DEPTH = 2;
endpackage : scan_regs_pkg

// ### rtl/scan_data_regs.sv
// Purpose: Bypass, identification and boundary-cell test data registers.
// Assumes: The TAP states and current instruction come from logic on mclk.
// Notes: The test clock is sampled by mclk; it must stay under mclk/4.
`timescale 1ns/1ns
`default_nettype none
module scan_data_regs #(
  parameter logic [3:0] ID_VERSION = 4'h1,    // Arbitrary value.
  parameter logic [15:0] ID_PART = 16'h1234,  // Arbitrary value.
  parameter logic [10:0] ID_MAKER = 11'h0AB   // Arbitrary value.
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tap_reset,
  input wire logic tap_capture_dr,
  input wire logic tap_shift_dr,
  input wire logic tap_update_dr,
  input wire logic tap_shift_ir,
  input wire logic ir_serial_out,
  input wire logic [3:0] instr,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic [scan_regs_pkg::DATA_BITS-1:0] pad_d_in,
  output logic [scan_regs_pkg::DATA_BITS-1:0] core_d_in,
  input wire logic [scan_regs_pkg::DATA_BITS-1:0] core_d_out,
  input wire logic core_d_off,
  output logic [scan_regs_pkg::DATA_BITS-1:0] pad_d_out,
  output logic pad_d_oe,
  input wire logic core_a_out,
  input wire logic core_a_en,
  output logic pad_a_out,
  output logic pad_a_oe
);
  import scan_regs_pkg::*;

  // -------------------------------------------------------------
  // Pin synchronisers and test clock edge detection.
  // -------------------------------------------------------------
  logic [2:0] meta_reg;   // First stage of each synchroniser.
  logic [2:0] sync_reg;   // Second stage: tck, tdi, trst_n.
  logic tck_last_reg;     // Previous synchronised test clock.
  logic tck_rise;         // One-cycle pulse at a rising test clock.
  logic tck_fall;         // One-cycle pulse at a falling test clock.
  logic test_rst;         // Test logic reset from pin or state.

  // Two flops on every pin; only the second stage feeds logic.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 3'h4;
      sync_reg <= 3'h4;
      tck_last_reg <= 1'b0;
    end else begin
      meta_reg <= {trst_n, tdi, tck};
      sync_reg <= meta_reg;
      tck_last_reg <= sync_reg[0];
    end
  end

  // Edges come only from sampled levels, so a stopped clock holds all state that a test reset does not clear.
  assign tck_rise = sync_reg[0] & ~tck_last_reg;
  assign tck_fall = ~sync_reg[0] & tck_last_reg;
  assign test_rst = ~sync_reg[2] | tap_reset;

  // -------------------------------------------------------------
  // Instruction decode.
  // -------------------------------------------------------------
  logic sel_chain;    // Boundary chain is the serial path.
  logic sel_id;       // Identification word is the serial path.
  logic test_mode;    // Extest or intest: cells drive from update stage.
  logic clamp_mode;   // Clamp or clampz: outputs from stored values.
  logic float_mode;   // High-impedance or clampz: outputs disabled.
  logic intest_mode;  // Internal test captures core-facing values.

  // Unknown codes fall to the bypass path, the safe choice.
  assign sel_chain = (instr == INS_SAMPLE) | test_mode;
  assign sel_id = (instr == INS_IDCODE);
  assign intest_mode = (instr == INS_INTEST);
  assign test_mode = (instr == INS_EXTEST) | intest_mode;
  assign clamp_mode = (instr == INS_CLAMP) | (instr == INS_CLAMPZ);
  assign float_mode = (instr == INS_HIGHZ) | (instr == INS_CLAMPZ);

  // -------------------------------------------------------------
  // Output buffer between the shift stage and the test data output.
  // -------------------------------------------------------------
  logic [BUF_W-1:0] buf_mem_reg [BUF_DEPTH];  // Entries, by index.
  logic buf_wr_reg;                           // Write index.
  logic buf_rd_reg;                           // Read index.
  logic [1:0] buf_cnt_reg;                    // Entries held.
  logic buf_in_valid;                         // A bit leaves a register.
  logic buf_in_ready;                         // Room for one more bit.
  logic [BUF_W-1:0] buf_in_data;              // Bit leaving the path.
  logic buf_out_valid;                        // A bit waits for the pin.
  logic buf_out_ready;                        // Pin takes a bit now.
  logic shift_go;                             // Shift step allowed.

  // A full buffer stalls the data register shift, so no data register bit is dropped; shift-IR bits are not stalled.
  assign buf_in_ready = (buf_cnt_reg != 2'(BUF_DEPTH));
  assign buf_out_valid = (buf_cnt_reg != 2'h0);
  assign buf_out_ready = tck_fall;
  assign shift_go = tck_rise & buf_in_ready;
  assign buf_in_valid = tck_rise & (tap_shift_dr | tap_shift_ir);

  // Push and pop bookkeeping; a test reset empties the buffer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else if (test_rst) begin
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_mem_reg[buf_wr_reg] <= buf_in_data;
        buf_wr_reg <= ~buf_wr_reg;
      end
      if (buf_out_valid && buf_out_ready) begin
        buf_rd_reg <= ~buf_rd_reg;
      end
      buf_cnt_reg <= buf_cnt_reg + 2'(buf_in_valid & buf_in_ready)
        - 2'(buf_out_valid & buf_out_ready);
    end
  end

  // The pin data changes only on the falling test clock; a test reset drops the enable at once.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      if (buf_out_valid) begin
        tdo_out <= buf_mem_reg[buf_rd_reg][0];
      end
      tdo_oe <= (tap_shift_dr | tap_shift_ir) & ~test_rst;
    end else if (test_rst) begin
      tdo_oe <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // Bypass stage and identification register.
  // -------------------------------------------------------------
  logic bypass_reg;             // One-bit bypass stage, no parallel out.
  logic [ID_W-1:0] id_reg;      // Identification shift register.
  logic [ID_W-1:0] id_code;     // Fixed code, nothing programmable.

  assign id_code = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Capture and shift on the rising test clock.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bypass_reg <= 1'b0;
      id_reg <= '0;
    end else if (test_rst) begin
      bypass_reg <= 1'b0;
      id_reg <= '0;
    end else if (tck_rise && tap_capture_dr) begin
      bypass_reg <= BYPASS_CAPTURE;
      if (sel_id) begin
        id_reg <= id_code;
      end
    end else if (shift_go && tap_shift_dr) begin
      if (sel_id) begin
        id_reg <= {sync_reg[1], id_reg[ID_W-1:1]};
      end else if (!sel_chain) begin
        bypass_reg <= sync_reg[1];
      end
    end
  end

  // -------------------------------------------------------------
  // Boundary cell chain: shift stage and update latch per cell.
  // -------------------------------------------------------------
  logic [CHAIN_LEN-1:0] bs_shift_reg;  // Capture and shift stages.
  logic [CHAIN_LEN-1:0] bs_upd_reg;    // Update latches, one per cell.
  logic [CHAIN_LEN-1:0] bs_cap;        // Value each cell captures.

  // Serial source to the buffer follows the selected path.
  always_comb begin
    if (tap_shift_ir) begin
      buf_in_data = ir_serial_out;
    end else if (sel_id) begin
      buf_in_data = id_reg[0];
    end else if (sel_chain) begin
      buf_in_data = bs_shift_reg[0];
    end else begin
      buf_in_data = bypass_reg;
    end
  end

  // Per data bit: input cell then output cell, bit 22 (data bit 9) nearest input.
  for (genvar j = 0; j < DATA_BITS; j++) begin : g_data_cells
    localparam int IN_IDX = CHAIN_LEN - 1 - 2 * j;
    localparam int OUT_IDX = CHAIN_LEN - 2 - 2 * j;
    localparam int BIT = DATA_BITS - 1 - j;
    // Intest sees the complement of what the cell feeds the core.
    assign bs_cap[IN_IDX] = intest_mode ? ~core_d_in[BIT] : pad_d_in[BIT];
    assign bs_cap[OUT_IDX] = (instr == INS_EXTEST) ? pad_d_out[BIT] : core_d_out[BIT];
    // Test modes drive the core from the update latch.
    assign core_d_in[BIT] = test_mode ? bs_upd_reg[IN_IDX] : pad_d_in[BIT];
    assign pad_d_out[BIT] = (test_mode | clamp_mode) ? bs_upd_reg[OUT_IDX]
      : core_d_out[BIT];
  end

  // Enable cells capture the core's own control levels outside extest: core_d_off and core_a_en.
  assign bs_cap[DOE_IDX] = (instr == INS_EXTEST) ? ~pad_d_oe : core_d_off;
  assign bs_cap[AOUT_IDX] = (instr == INS_EXTEST) ? pad_a_out : core_a_out;
  assign bs_cap[AOE_IDX] = (instr == INS_EXTEST) ? pad_a_oe : core_a_en;

  // Low-active data enable: 1 floats; high-active address enable: 0 floats.
  assign pad_d_oe = float_mode ? 1'b0
    : (test_mode | clamp_mode) ? ~bs_upd_reg[DOE_IDX] : ~core_d_off;
  assign pad_a_oe = float_mode ? 1'b0
    : (test_mode | clamp_mode) ? bs_upd_reg[AOE_IDX] : core_a_en;
  assign pad_a_out = (test_mode | clamp_mode) ? bs_upd_reg[AOUT_IDX] : core_a_out;

  // Capture and shift only while the chain is the path; clamps leave it alone.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bs_shift_reg <= '0;
    end else if (sel_chain && tck_rise && tap_capture_dr) begin
      bs_shift_reg <= bs_cap;
    end else if (sel_chain && shift_go && tap_shift_dr) begin
      bs_shift_reg <= {sync_reg[1], bs_shift_reg[CHAIN_LEN-1:1]};
    end
  end

  // Update latches load on the falling test clock in update-data.
  // Contents are not kept across a test reset; cleared for a known state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bs_upd_reg <= '0;
    end else if (test_rst) begin
      bs_upd_reg <= '0;
    end else if (sel_chain && tck_fall && tap_update_dr) begin
      bs_upd_reg <= bs_shift_reg;
    end
  end

endmodule : scan_data_regs
`default_nettype wire

// ### sim/scan_data_regs_properties.sv
// Purpose: Port properties of the scan data registers.
// Assumes: Scan pins reach mclk through synchronisers.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ns
`default_nettype none
module scan_data_regs_properties import scan_regs_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tap_shift_dr,
  input wire logic tap_shift_ir,
  input wire logic tap_update_dr,
  input wire logic [3:0] instr,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic [DATA_BITS-1:0] pad_d_in,
  input wire logic [DATA_BITS-1:0] core_d_in,
  input wire logic [DATA_BITS-1:0] core_d_out,
  input wire logic core_d_off,
  input wire logic [DATA_BITS-1:0] pad_d_out,
  input wire logic pad_d_oe,
  input wire logic core_a_out,
  input wire logic core_a_en,
  input wire logic pad_a_out,
  input wire logic pad_a_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Data shifting stops; tdo must let go within 30 mclk cycles.
  sequence shift_left;
    $fell(tap_shift_dr) && !tap_shift_ir;
  endsequence
  // Normal-mode instructions pass pins straight through.
  sequence normal_mode;
    instr == INS_SAMPLE || instr == INS_IDCODE || instr == INS_BYPASS;
  endsequence
  chk_oe_rise: assert property ($rose(tdo_oe) |-> tap_shift_dr || tap_shift_ir)
    else $error("tdo driver enabled outside a shift state");
  chk_oe_drop: assert property (shift_left |-> ##[1:30] !tdo_oe)
    else $error("tdo driver still on after leaving shift");
  chk_tdo_fall: assert property ($changed(tdo_out) |-> !tck)
    else $error("tdo changed while the test clock was high");
  chk_norm_data: assert property (normal_mode |->
    core_d_in == pad_d_in && pad_d_out == core_d_out && pad_a_out == core_a_out)
    else $error("normal mode data not passed straight");
  chk_norm_enab: assert property (normal_mode |->
    pad_d_oe == !core_d_off && pad_a_oe == core_a_en)
    else $error("normal mode enables not passed straight");
  chk_ext_hold: assert property (instr == INS_EXTEST && $past(instr) == INS_EXTEST
    && !$past(tap_update_dr) |-> $stable(pad_d_out) && $stable(pad_a_oe))
    else $error("extest pads moved without an update");
  chk_clamp_hold: assert property (instr == INS_CLAMP && $past(instr) == INS_CLAMP
    |-> $stable(pad_d_out) && $stable(pad_d_oe))
    else $error("clamp pads moved");
  chk_highz_off: assert property (instr == INS_HIGHZ |-> !pad_d_oe && !pad_a_oe)
    else $error("high impedance left a driver on");
endmodule : scan_data_regs_properties
`default_nettype wire

// ### sim/tap_ctrl_model.sv
// Purpose: Test controller model for the scan pins and TAP levels.
// Assumes: Levels are held across every test clock edge they qualify.
// Notes: The test clock stands still between scans.
`timescale 1ns/1ns
`default_nettype none
module tap_ctrl_model (
  output logic tck,
  output logic tdi,
  output logic trst_n,
  output logic cap,
  output logic sft,
  output logic upd,
  output logic [3:0] instr,
  input wire logic tdo_out
);
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    trst_n = 1'b0;
    cap = 1'b0;
    sft = 1'b0;
    upd = 1'b0;
    instr = 4'hF;
  end
  // One 125 ns test clock; tdo is read late in the low phase.
  // Non-blocking drives keep pin edges off the race with mclk sampling.
  task automatic pulse(output logic q);
    #10 tck <= 1'b1;
    #60 tck <= 1'b0;
    #55 q = tdo_out;
  endtask : pulse
  // Capture, shift n bits first bit first, then update.
  task automatic scan(input logic [3:0] code, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    instr <= code;
    cap <= 1'b1;
    pulse(q);
    cap <= 1'b0;
    sft <= 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi <= din[i];
      pulse(dout[i]);
    end
    sft <= 1'b0;
    upd <= 1'b1;
    pulse(q);
    upd <= 1'b0;
    tdi <= ~tdi; // Idle data never repeats the last bit.
  endtask : scan
  // Test reset pulse; mode-select is held high by the TAP side.
  task automatic reset_tap;
    trst_n <= 1'b0;
    #100 trst_n <= 1'b1;
  endtask : reset_tap
endmodule : tap_ctrl_model
`default_nettype wire

// ### sim/boundary_scan_data_registers_tb.sv
// Purpose: Self-checking bench for the scan data registers.
// Assumes: The controller model drives all test pins.
// Notes: Vectors list cells from the address enable upward.
`timescale 1ns/1ns
`default_nettype none
module boundary_scan_data_registers_tb;
  import scan_regs_pkg::*;
  localparam logic [3:0] VER = 4'h6; // Arbitrary value.
  localparam logic [15:0] PART = 16'hC35A; // Arbitrary value.
  localparam logic [10:0] MAKR = 11'h2D1; // Arbitrary value.
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic core_d_off = 1'b0;
  logic core_a_out = 1'b0;
  logic core_a_en = 1'b0;
  logic tap_reset = 1'b0; // Test-logic-reset state level.
  logic ir_shift = 1'b0; // Shift-IR state level.
  logic ir_bit = 1'b0; // Instruction register serial bit.
  logic [9:0] pad_d_in = 10'h000;
  logic [9:0] core_d_out = 10'h000;
  logic tck, tdi, trst_n, cap, sft, upd, tdo_out, tdo_oe, pad_d_oe, pad_a_out, pad_a_oe;
  logic [3:0] instr;
  logic [9:0] core_d_in, pad_d_out;
  logic [63:0] got;
  int failures = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  scan_data_regs #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKR)) scan_data_regs_inst (
    .mclk(mclk), .rst_n(rst_n), .tck(tck), .tdi(tdi), .trst_n(trst_n),
    .tap_reset(tap_reset), .tap_capture_dr(cap), .tap_shift_dr(sft), .tap_update_dr(upd),
    .tap_shift_ir(ir_shift), .ir_serial_out(ir_bit), .instr(instr), .tdo_out(tdo_out),
    .tdo_oe(tdo_oe),
    .pad_d_in(pad_d_in), .core_d_in(core_d_in), .core_d_out(core_d_out),
    .core_d_off(core_d_off), .pad_d_out(pad_d_out), .pad_d_oe(pad_d_oe),
    .core_a_out(core_a_out), .core_a_en(core_a_en), .pad_a_out(pad_a_out),
    .pad_a_oe(pad_a_oe));
  tap_ctrl_model tap_ctrl_model_inst (.tck(tck), .tdi(tdi), .trst_n(trst_n), .cap(cap),
    .sft(sft), .upd(upd), .instr(instr), .tdo_out(tdo_out));
  task automatic check(input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Chain image: enables and address at 0..2, then output/input cell pairs.
  function automatic logic [63:0] vec(logic [9:0] dq, di, logic oe_n, ao, ae);
    vec = {61'h0, oe_n, ao, ae};
    for (int j = 0; j < 10; j++) begin
      vec[3+2*j] = dq[j];
      vec[4+2*j] = di[j];
    end
  endfunction : vec
  task automatic set_core(logic [9:0] pin, dq, logic off, ao, ae);
    @(posedge mclk);
    pad_d_in <= pin;
    core_d_out <= dq;
    core_d_off <= off;
    core_a_out <= ao;
    core_a_en <= ae;
    repeat (4) @(posedge mclk);
  endtask : set_core
  // Shift-IR drives the instruction bit out; leaving shift or a test reset lets go.
  task automatic t_shift_ir;
    logic q;
    @(posedge mclk);
    ir_shift <= 1'b1;
    ir_bit <= 1'b1;
    tap_ctrl_model_inst.pulse(q);
    check(q, 1'b1);
    check(tdo_oe, 1'b1);
    ir_shift <= 1'b0;
    tap_ctrl_model_inst.pulse(q);
    check(tdo_oe, 1'b0);
    ir_shift <= 1'b1;
    tap_ctrl_model_inst.pulse(q);
    check(tdo_oe, 1'b1);
    @(posedge mclk);
    tap_reset <= 1'b1;
    repeat (2) @(posedge mclk);
    check(tdo_oe, 1'b0);
    tap_reset <= 1'b0;
    ir_shift <= 1'b0;
  endtask : t_shift_ir
  task automatic t_sample;
    set_core(10'h15C, 10'h2A5, 1'b1, 1'b1, 1'b0);
    check({pad_d_oe, core_d_in, pad_d_out}, {1'b0, 10'h15C, 10'h2A5});
    tap_ctrl_model_inst.scan(INS_SAMPLE, 23, vec(10'h3C3, 10'h0F0, 1'b1, 1'b0, 1'b0), got);
    check(got[22:0], vec(10'h2A5, 10'h15C, 1'b1, 1'b1, 1'b0));
  endtask : t_sample
  task automatic t_extest;
    logic [63:0] e;
    e = vec(10'h3C3, 10'h15C, 1'b1, 1'b0, 1'b0);
    tap_ctrl_model_inst.scan(INS_EXTEST, 23, vec(10'h3C3, 10'h0F0, 1'b0, 1'b1, 1'b1), got);
    check(got[22:0], e);
    check({pad_d_oe, pad_a_oe, pad_a_out, pad_d_out, core_d_in}, {3'h7, 20'hF0CF0});
    tap_ctrl_model_inst.scan(INS_EXTEST, 23, vec(10'h3C3, 10'h0F0, 1'b1, 1'b1, 1'b0), got);
    check({pad_d_oe, pad_a_oe}, 64'h0);
  endtask : t_extest
  task automatic t_clamp_bypass;
    logic [3:0] codes [5] = '{INS_BYPASS, INS_CLAMP, INS_HIGHZ, INS_CLAMPZ, 4'hB};
    foreach (codes[i]) begin
      tap_ctrl_model_inst.scan(codes[i], 9, 64'h0B5, got);
      check(got[8:0], 64'h16A);
      if (codes[i] == INS_CLAMP) check({pad_d_out, pad_a_out}, 64'h787);
      if (codes[i] inside {INS_HIGHZ, INS_CLAMPZ}) check({pad_d_oe, pad_a_oe}, 64'h0);
    end
  endtask : t_clamp_bypass
  task automatic t_idcode;
    tap_ctrl_model_inst.scan(INS_IDCODE, 34, 64'h3, got);
    check(got[33:0], {2'b11, VER, PART, MAKR, 1'b1});
  endtask : t_idcode
  task automatic t_intest;
    // Guard values preloaded first: drivers stay off until the final all-zero scan turns the data driver on.
    tap_ctrl_model_inst.scan(INS_SAMPLE, 23, vec(10'h000, 10'h0F0, 1'b1, 1'b0, 1'b0), got);
    tap_ctrl_model_inst.scan(INS_INTEST, 23, vec(10'h000, 10'h155, 1'b1, 1'b0, 1'b0), got);
    check(got[22:0], vec(10'h2A5, 10'h30F, 1'b1, 1'b1, 1'b0));
    check(core_d_in, 64'h155);
    set_core(10'h15C, 10'h0CC, 1'b1, 1'b1, 1'b0);
    tap_ctrl_model_inst.scan(INS_INTEST, 23, 64'h0, got);
    check(got[22:0], vec(10'h0CC, 10'h2AA, 1'b1, 1'b1, 1'b0));
  endtask : t_intest
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    tap_ctrl_model_inst.reset_tap();
    t_shift_ir();
    t_sample();
    t_extest();
    t_clamp_bypass();
    t_idcode();
    t_intest();
    tally_and_finish();
  end
  // Watchdog well beyond the roughly 31 us the scans need.
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule : boundary_scan_data_registers_tb
bind scan_data_regs scan_data_regs_properties scan_data_regs_properties_inst (
  .mclk(mclk), .rst_n(rst_n), .tck(tck), .tap_shift_dr(tap_shift_dr),
  .tap_shift_ir(tap_shift_ir), .tap_update_dr(tap_update_dr), .instr(instr),
  .tdo_out(tdo_out), .tdo_oe(tdo_oe), .pad_d_in(pad_d_in), .core_d_in(core_d_in),
  .core_d_out(core_d_out), .core_d_off(core_d_off), .pad_d_out(pad_d_out),
  .pad_d_oe(pad_d_oe), .core_a_out(core_a_out), .core_a_en(core_a_en),
  .pad_a_out(pad_a_out), .pad_a_oe(pad_a_oe));
`default_nettype wire
